// >>> shared/dbu_defs.vh
`ifndef DBU_DEFS_VH
`define DBU_DEFS_VH

// Opcode fields and values
`define DBU_CONDD_OP    8'h8f
`define DBU_BF_OP       8'h8b
`define DBU_BT_OP       8'h89
`define DBU_BTS_OP      8'h8d
`define DBU_RELD_OP     4'ha
`define DBU_BSR_OP      4'hb
`define DBU_GRP0_OP     4'h0
`define DBU_GRP4_OP     4'h4
`define DBU_FARD_LO     8'h23
`define DBU_BSRF_LO     8'h03
`define DBU_JMP_LO      8'h2b
`define DBU_JSR_LO      8'h0b
`define DBU_RTS_CODE    16'h000b
`define DBU_RTE_CODE    16'h002b

// Instruction field positions
`define DBU_HI_FLD      15:8
`define DBU_LO_FLD      7:0
`define DBU_TOP_FLD     15:12
`define DBU_D8_FLD      7:0
`define DBU_D12_FLD     11:0
`define DBU_D8_SGN      7
`define DBU_D12_SGN     11
`define DBU_D8_EXT      23
`define DBU_D12_EXT     19

// Reset values
`define DBU_PC_RST      32'h0000_0000
`define DBU_CYC_RST     2'h0

// PC offsets in bytes
`define DBU_SLOT_OFS    32'h0000_0002
`define DBU_REF_OFS     32'h0000_0004

// Execution cycle counts
`define DBU_CYC_TAKEN   2'h2
`define DBU_CYC_NOT     2'h1

// Controller states, one-hot
`define DBU_ST_IDLE     2'h1
`define DBU_ST_SLOT     2'h2

`endif

// >>> design/dbu_branch_unit.v
`timescale 1ns/1ps
`include "dbu_defs.vh"

module dbu_branch_unit (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_sys_rst,

  // Decoded instruction stream
  input  wire        i_instr_valid,
  input  wire [15:0] i_instr,
  input  wire [31:0] i_instr_pc,

  // Core state read at decode
  input  wire        i_t_flag,
  input  wire [31:0] i_rn_data,

  // Fetch control
  output reg         o_slot_fetch,
  output reg  [31:0] o_slot_pc,
  output reg         o_redirect,
  output reg  [31:0] o_redirect_pc,

  // Exception control
  output reg         o_int_block,
  output reg         o_addr_err_block,
  output reg         o_illegal_slot,
  output reg  [31:0] o_illegal_pc,

  // Status to the core
  output reg         o_branch_done,
  output reg  [1:0]  o_exec_cycles,
  output reg         o_t_hold
);

  localparam [1:0] ST_IDLE = `DBU_ST_IDLE;
  localparam [1:0] ST_SLOT = `DBU_ST_SLOT;

  // Any branch class, for slot checking
  function is_branch;
    input [15:0] ins;
    reg   [7:0]  hi;
    reg   [7:0]  lo;
    begin
      hi = ins[`DBU_HI_FLD];
      lo = ins[`DBU_LO_FLD];
      is_branch =
        (hi == `DBU_CONDD_OP) ||
        (hi == `DBU_BF_OP) ||
        (hi == `DBU_BT_OP) ||
        (hi == `DBU_BTS_OP) ||
        (ins[`DBU_TOP_FLD] == `DBU_RELD_OP) ||
        (ins[`DBU_TOP_FLD] == `DBU_BSR_OP) ||
        ((ins[`DBU_TOP_FLD] == `DBU_GRP0_OP) &&
         ((lo == `DBU_FARD_LO) || (lo == `DBU_BSRF_LO))) ||
        ((ins[`DBU_TOP_FLD] == `DBU_GRP4_OP) &&
         ((lo == `DBU_JMP_LO) || (lo == `DBU_JSR_LO))) ||
        (ins == `DBU_RTS_CODE) ||
        (ins == `DBU_RTE_CODE);
    end
  endfunction

  // Opcode fields
  wire [7:0]  op_hi;
  wire [7:0]  op_lo;
  wire [3:0]  op_top;

  assign op_hi  = i_instr[`DBU_HI_FLD];
  assign op_lo  = i_instr[`DBU_LO_FLD];
  assign op_top = i_instr[`DBU_TOP_FLD];

  // Decoded kinds of this block
  wire dec_cond;
  wire dec_rel;
  wire dec_far;
  wire dec_any;

  assign dec_cond = (op_hi == `DBU_CONDD_OP);
  assign dec_rel  = (op_top == `DBU_RELD_OP);
  assign dec_far  = (op_top == `DBU_GRP0_OP) &&
                    (op_lo == `DBU_FARD_LO);
  assign dec_any  = is_branch(i_instr);

  // Displacement fields
  wire [7:0]  d8_fld;
  wire [11:0] d12_fld;

  assign d8_fld  = i_instr[`DBU_D8_FLD];
  assign d12_fld = i_instr[`DBU_D12_FLD];

  // Sign-extended doubled displacements
  wire [31:0] disp8;
  wire [31:0] disp12;

  assign disp8  = {{`DBU_D8_EXT{d8_fld[`DBU_D8_SGN]}}, d8_fld, 1'b0};
  assign disp12 = {{`DBU_D12_EXT{d12_fld[`DBU_D12_SGN]}}, d12_fld, 1'b0};

  // Reference PC, second instruction on
  wire [31:0] ref_pc;

  assign ref_pc = i_instr_pc + `DBU_REF_OFS;

  // Targets formed at decode
  wire [31:0] tgt_cond;
  wire [31:0] tgt_rel;
  wire [31:0] tgt_far;

  assign tgt_cond = ref_pc + disp8;
  assign tgt_rel  = ref_pc + disp12;
  assign tgt_far  = ref_pc + i_rn_data;

  // Flag clear means taken; flag only read
  wire cond_taken;

  assign cond_taken = dec_cond && !i_t_flag;

  // Branches that open a delay slot
  wire open_slot;

  assign open_slot = cond_taken || dec_rel || dec_far;

  // Controller state
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;

  // Captured target and far-branch marker
  reg  [31:0] target_q;
  reg  [31:0] target_d;
  reg         far_q;
  reg         far_d;

  // Next values of the fetch outputs
  reg         slot_fetch_d;
  reg  [31:0] slot_pc_d;
  reg         redirect_d;
  reg  [31:0] redirect_pc_d;

  // Next values of the exception outputs
  reg         int_block_d;
  reg         addr_err_block_d;
  reg         illegal_d;
  reg  [31:0] illegal_pc_d;

  // Next values of the status outputs
  reg         done_d;
  reg  [1:0]  cycles_d;
  reg         t_hold_d;

  // State decodes
  wire in_idle;
  wire in_slot;

  assign in_idle = (state_q == ST_IDLE);
  assign in_slot = (state_q == ST_SLOT);

  // Acceptance of instructions per state
  wire take_slot;
  wire take_nop;
  wire slot_done;
  wire slot_wait;

  assign take_slot = in_idle && i_instr_valid && open_slot;
  assign take_nop  = in_idle && i_instr_valid && dec_cond && !open_slot;
  assign slot_done = in_slot && i_instr_valid;
  assign slot_wait = in_slot && !i_instr_valid;

  // Target latched at decode, before the slot can write registers
  always @* begin
    target_d = target_q;
    far_d    = far_q;
    if (take_slot) begin
      target_d = dec_cond ? tgt_cond :
                 dec_rel ? tgt_rel : tgt_far;
      far_d    = dec_far;
    end else if (slot_done) begin
      far_d    = 1'b0;
    end
  end

  // Cycle count and flag hold of a decoded branch
  always @* begin
    cycles_d = o_exec_cycles;
    t_hold_d = 1'b0;
    if (take_slot) begin
      cycles_d = `DBU_CYC_TAKEN;
      t_hold_d = 1'b1;
    end else if (take_nop) begin
      cycles_d = `DBU_CYC_NOT;
      t_hold_d = 1'b1;
    end
  end

  // Sequencing of branch and slot
  always @* begin
    state_d          = state_q;
    slot_fetch_d     = 1'b0;
    slot_pc_d        = o_slot_pc;
    redirect_d       = 1'b0;
    redirect_pc_d    = o_redirect_pc;
    int_block_d      = o_int_block;
    addr_err_block_d = o_addr_err_block;
    illegal_d        = 1'b0;
    illegal_pc_d     = o_illegal_pc;
    done_d           = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (take_slot) begin
          slot_fetch_d     = 1'b1;
          slot_pc_d        = i_instr_pc + `DBU_SLOT_OFS;
          int_block_d      = 1'b1;
          addr_err_block_d = dec_far;
          state_d          = ST_SLOT;
        end else if (take_nop) begin
          // Not taken: a plain no-op, no slot
          done_d           = 1'b1;
          int_block_d      = 1'b0;
        end
      end
      ST_SLOT: begin
        if (slot_done) begin
          int_block_d      = 1'b0;
          addr_err_block_d = 1'b0;
          done_d           = 1'b1;
          state_d          = ST_IDLE;
          if (dec_any) begin
            // Branch in a slot goes to exceptions
            illegal_d    = 1'b1;
            illegal_pc_d = i_instr_pc;
          end else begin
            // Slot ran; now redirect fetch
            redirect_d    = 1'b1;
            redirect_pc_d = target_q;
          end
        end else if (slot_wait) begin
          // Still waiting on the slot: blocks stay up
          int_block_d      = 1'b1;
          addr_err_block_d = far_q;
        end
      end
      default: begin
        state_d          = ST_IDLE;
        int_block_d      = 1'b0;
        addr_err_block_d = 1'b0;
      end
    endcase
  end

  // Controller registers
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q  <= ST_IDLE;
      target_q <= `DBU_PC_RST;
      far_q    <= 1'b0;
    end else begin
      state_q  <= state_d;
      target_q <= target_d;
      far_q    <= far_d;
    end
  end

  // Fetch output registers
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_slot_fetch  <= 1'b0;
      o_slot_pc     <= `DBU_PC_RST;
      o_redirect    <= 1'b0;
      o_redirect_pc <= `DBU_PC_RST;
    end else begin
      o_slot_fetch  <= slot_fetch_d;
      o_slot_pc     <= slot_pc_d;
      o_redirect    <= redirect_d;
      o_redirect_pc <= redirect_pc_d;
    end
  end

  // Exception output registers
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_int_block      <= 1'b0;
      o_addr_err_block <= 1'b0;
      o_illegal_slot   <= 1'b0;
      o_illegal_pc     <= `DBU_PC_RST;
    end else begin
      o_int_block      <= int_block_d;
      o_addr_err_block <= addr_err_block_d;
      o_illegal_slot   <= illegal_d;
      o_illegal_pc     <= illegal_pc_d;
    end
  end

  // Status output registers
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_branch_done <= 1'b0;
      o_exec_cycles <= `DBU_CYC_RST;
      o_t_hold      <= 1'b0;
    end else begin
      o_branch_done <= done_d;
      o_exec_cycles <= cycles_d;
      o_t_hold      <= t_hold_d;
    end
  end

endmodule // dbu_branch_unit

// >>> tb/dbu_branch_unit_sva.sv
`timescale 1ns/1ps
module dbu_branch_unit_chk (
  // Clock and reset
  input wire        i_clk,
  input wire        i_sys_rst,
  // Instruction side
  input wire        i_instr_valid,
  input wire [15:0] i_instr,
  input wire [31:0] i_instr_pc,
  input wire        i_t_flag,
  input wire [31:0] i_rn_data,
  // Block outputs
  input wire        o_slot_fetch,
  input wire [31:0] o_slot_pc,
  input wire        o_redirect,
  input wire [31:0] o_redirect_pc,
  input wire        o_int_block,
  input wire        o_addr_err_block,
  input wire        o_illegal_slot,
  input wire [31:0] o_illegal_pc,
  input wire        o_branch_done,
  input wire [1:0]  o_exec_cycles,
  input wire        o_t_hold
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Instruction classes seen outside a slot
  wire fresh   = i_instr_valid && !o_int_block;
  wire is_rel  = i_instr[15:12] == 4'ha;
  wire is_cond = i_instr[15:8] == 8'h8f;
  wire is_far  = i_instr[15:12] == 4'h0 && i_instr[7:0] == 8'h23;
  // Every branch class that is illegal in a slot
  wire grp0_br = i_instr[15:12] == 4'h0 && (i_instr[7:0] == 8'h03 || i_instr[7:0] == 8'h23
    || i_instr == 16'h000b || i_instr == 16'h002b);
  wire grp4_br = i_instr[15:12] == 4'h4 && (i_instr[7:0] == 8'h2b || i_instr[7:0] == 8'h0b);
  wire cond_br = is_cond || i_instr[15:8] == 8'h8b || i_instr[15:8] == 8'h89
    || i_instr[15:8] == 8'h8d;
  wire slot_br = is_rel || i_instr[15:12] == 4'hb || cond_br || grp0_br || grp4_br;
  logic [31:0] tgt_q;
  // Expected target taken at decode, before any slot write
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      tgt_q <= 32'h0;
    end else if (fresh && is_rel) begin
      tgt_q <= i_instr_pc + 32'h4 + {{19{i_instr[11]}}, i_instr[11:0], 1'b0};
    end else if (fresh && is_cond && !i_t_flag) begin
      tgt_q <= i_instr_pc + 32'h4 + {{23{i_instr[7]}}, i_instr[7:0], 1'b0};
    end else if (fresh && is_far) begin
      tgt_q <= i_instr_pc + 32'h4 + i_rn_data;
    end
  end
  sequence s_rel; fresh && is_rel; endsequence
  sequence s_cond_t0; fresh && is_cond && !i_t_flag; endsequence
  sequence s_cond_t1; fresh && is_cond && i_t_flag; endsequence
  sequence s_far; fresh && is_far; endsequence
  sequence s_slot_ok; o_int_block && i_instr_valid && !slot_br; endsequence
  sequence s_slot_br; o_int_block && i_instr_valid && slot_br; endsequence
  rel_open_a: assert property (s_rel |=> o_slot_fetch && o_int_block && o_t_hold
    && o_exec_cycles == 2'h2 && o_slot_pc == $past(i_instr_pc) + 32'h2) else $error("rel open");
  cond_taken_a: assert property (s_cond_t0 |=> o_slot_fetch && o_int_block
    && o_exec_cycles == 2'h2) else $error("cond taken");
  cond_not_a: assert property (s_cond_t1 |=> !o_int_block && !o_slot_fetch
    && o_branch_done && o_t_hold && o_exec_cycles == 2'h1) else $error("cond not taken");
  far_block_a: assert property (s_far |=> o_int_block && o_addr_err_block)
    else $error("far block");
  slot_run_a: assert property (s_slot_ok |=> o_redirect && o_branch_done && !o_int_block
    && !o_addr_err_block && !o_illegal_slot) else $error("slot run");
  slot_bad_a: assert property (s_slot_br |=> o_illegal_slot && !o_redirect
    && o_illegal_pc == $past(i_instr_pc)) else $error("slot illegal");
  target_ok_a: assert property (o_redirect |-> o_redirect_pc == tgt_q)
    else $error("target");
  block_hold_a: assert property (o_int_block && !i_instr_valid |=> o_int_block
    && $stable(o_slot_pc)) else $error("block hold");
endmodule // dbu_branch_unit_chk

bind dbu_branch_unit dbu_branch_unit_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_instr_pc(i_instr_pc),
  .i_t_flag(i_t_flag), .i_rn_data(i_rn_data), .o_slot_fetch(o_slot_fetch),
  .o_slot_pc(o_slot_pc), .o_redirect(o_redirect), .o_redirect_pc(o_redirect_pc),
  .o_int_block(o_int_block), .o_addr_err_block(o_addr_err_block),
  .o_illegal_slot(o_illegal_slot), .o_illegal_pc(o_illegal_pc),
  .o_branch_done(o_branch_done), .o_exec_cycles(o_exec_cycles), .o_t_hold(o_t_hold));

// >>> tb/dbu_branch_unit_bench.sv
`timescale 1ns/1ps
module dbu_branch_unit_bench;
  logic i_clk, i_sys_rst, i_instr_valid, i_t_flag;
  logic [15:0] i_instr;
  logic [31:0] i_instr_pc, i_rn_data;
  wire o_slot_fetch, o_redirect, o_int_block, o_addr_err_block, o_illegal_slot;
  wire o_branch_done, o_t_hold;
  wire [31:0] o_slot_pc, o_redirect_pc, o_illegal_pc;
  wire [1:0] o_exec_cycles;
  int fail_count = 0;
  int compares = 0;
  dbu_branch_unit u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .i_instr_pc(i_instr_pc), .i_t_flag(i_t_flag), .i_rn_data(i_rn_data),
    .o_slot_fetch(o_slot_fetch), .o_slot_pc(o_slot_pc), .o_redirect(o_redirect),
    .o_redirect_pc(o_redirect_pc), .o_int_block(o_int_block),
    .o_addr_err_block(o_addr_err_block), .o_illegal_slot(o_illegal_slot),
    .o_illegal_pc(o_illegal_pc), .o_branch_done(o_branch_done),
    .o_exec_cycles(o_exec_cycles), .o_t_hold(o_t_hold));
  // Core clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Verdict and end of run
  task end_sim;
    if (fail_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Flag and word comparisons
  task chk_b(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_w(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One instruction slot, driven just after the edge
  task step(input logic v, input logic [15:0] ins, input logic [31:0] pc, input logic t,
            input logic [31:0] rn);
    @(posedge i_clk);
    #1;
    i_instr_valid = v;
    i_instr = ins;
    i_instr_pc = pc;
    i_t_flag = t;
    i_rn_data = rn;
  endtask
  // Slot opened by a branch at pc
  task opened(input logic [31:0] pc, input logic far);
    chk_b(o_slot_fetch, 1'b1);
    chk_b(o_int_block, 1'b1);
    chk_b(o_addr_err_block, far);
    chk_b(o_t_hold, 1'b1);
    chk_w(o_slot_pc, pc + 32'h2);
    chk_w({30'h0, o_exec_cycles}, 32'h2);
  endtask
  // Slot consumed and fetch redirected
  task closed(input logic [31:0] tgt);
    chk_b(o_redirect, 1'b1);
    chk_w(o_redirect_pc, tgt);
    chk_b(o_int_block, 1'b0);
    chk_b(o_branch_done, 1'b1);
  endtask
  // Relative branch at the displacement limits
  task t_rel(input logic [11:0] d, input logic [31:0] tgt);
    step(1'b1, {4'ha, d}, 32'h0001_0000, 1'b0, 32'h0);
    step(1'b1, 16'h0009, 32'h0001_0002, 1'b0, 32'h0);
    opened(32'h0001_0000, 1'b0);
    step(1'b0, 16'h0000, 32'h0, 1'b0, 32'h0);
    closed(tgt);
  endtask
  // Conditional delayed branch, taken then not taken
  task t_cond;
    step(1'b1, 16'h8f80, 32'h2000, 1'b0, 32'h0);
    step(1'b1, 16'h0009, 32'h2002, 1'b0, 32'h0);
    opened(32'h2000, 1'b0);
    step(1'b1, 16'h8f7f, 32'h2004, 1'b1, 32'h0);
    closed(32'h1f04);
    step(1'b1, 16'ha004, 32'h2006, 1'b1, 32'h0);
    chk_b(o_int_block, 1'b0);
    chk_b(o_slot_fetch, 1'b0);
    chk_b(o_branch_done, 1'b1);
    chk_w({30'h0, o_exec_cycles}, 32'h1);
    step(1'b1, 16'h0009, 32'h2008, 1'b0, 32'h0);
    chk_b(o_illegal_slot, 1'b0);
    opened(32'h2006, 1'b0);
    step(1'b0, 16'h0000, 32'h0, 1'b0, 32'h0);
    closed(32'h2012);
  endtask
  // Far branch, idle wait in the slot, register rewritten by the slot
  task t_far;
    step(1'b1, 16'h0523, 32'h3000, 1'b0, 32'h0000_0100);
    step(1'b0, 16'h0000, 32'h0, 1'b0, 32'h5555_0000);
    opened(32'h3000, 1'b1);
    step(1'b1, 16'h350c, 32'h3002, 1'b0, 32'hdead_0000);
    chk_b(o_int_block, 1'b1);
    step(1'b0, 16'h0000, 32'h0, 1'b0, 32'h0);
    closed(32'h0000_3104);
    chk_b(o_addr_err_block, 1'b0);
  endtask
  // Branch found in a delay slot
  task t_illegal(input logic [15:0] br, input logic [15:0] slot);
    step(1'b1, br, 32'h4000, 1'b0, 32'h0);
    step(1'b1, slot, 32'h4002, 1'b0, 32'h0);
    step(1'b0, 16'h0000, 32'h0, 1'b0, 32'h0);
    chk_b(o_illegal_slot, 1'b1);
    chk_w(o_illegal_pc, 32'h4002);
    chk_b(o_redirect, 1'b0);
    chk_b(o_int_block, 1'b0);
  endtask
  // Watchdog
  initial begin
    repeat (1000) @(posedge i_clk);
    fail_count++;
    end_sim();
  end
  // Main sequence
  initial begin
    i_sys_rst = 1'b1;
    step(1'b0, 16'h0000, 32'h0, 1'b0, 32'h0);
    repeat (12) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    chk_b(o_int_block, 1'b0);
    t_rel(12'h800, 32'h0000_f004);
    t_rel(12'h7ff, 32'h0001_1002);
    t_cond();
    t_far();
    t_illegal(16'ha010, 16'h8f05);
    t_illegal(16'h8f00, 16'ha123);
    t_illegal(16'h0223, 16'h0323);
    end_sim();
  end
endmodule // dbu_branch_unit_bench
